/* logic/hsc_div.sv */
// Sequential restoring divider used for frequency and published-value scaling.
// Assumes start is only raised while idle; a zero denominator is treated as one.
`timescale 1ns/1ps
`default_nettype none
module hsc_div #(
  parameter int NW = 48,
  parameter int DW = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic [NW-1:0] quo,
  output logic done,
  output logic busy
);

  logic [NW-1:0] quo_q, quo_d;          // Numerator shifting out, quotient shifting in.
  logic [DW-1:0] rem_q, rem_d;          // Partial remainder.
  logic [DW-1:0] den_q, den_d;          // Latched denominator.
  logic [7:0] cnt_q, cnt_d;             // Bits still to produce.
  logic done_q, done_d;                 // One-cycle completion pulse.
  logic [DW:0] rem_sh;                  // Remainder with next numerator bit.

  ////////////////////////////////////////////////////////////////////////////////
  // One quotient bit per clock; NW clocks per division keeps the area tiny.
  always_comb begin
    quo_d = quo_q;
    rem_d = rem_q;
    den_d = den_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    rem_sh = {rem_q, quo_q[NW-1]};
    if (start && cnt_q == 8'h00) begin
      // A zero divisor would give all ones; one is the safer reading.
      den_d = (den == '0) ? DW'(1) : den;
      quo_d = num;
      rem_d = '0;
      cnt_d = 8'(NW);
    end else if (cnt_q != 8'h00) begin
      if (rem_sh >= {1'b0, den_q}) begin
        rem_d = DW'(rem_sh - {1'b0, den_q});
        quo_d = {quo_q[NW-2:0], 1'b1};
      end else begin
        rem_d = rem_sh[DW-1:0];
        quo_d = {quo_q[NW-2:0], 1'b0};
      end
      cnt_d = cnt_q - 8'h01;
      done_d = (cnt_q == 8'h01);
    end
  end

  // Register stage of the divider.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      quo_q <= '0;
      rem_q <= '0;
      den_q <= DW'(1);
      cnt_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      quo_q <= quo_d;
      rem_q <= rem_d;
      den_q <= den_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign quo = quo_q;
  assign done = done_q;
  assign busy = (cnt_q != 8'h00);

endmodule : hsc_div
`default_nettype wire

/* logic/hsc_pkg.sv */
// Shared constants and carrier types for the two-channel high speed pulse counter.
// Assumes a single 100 MHz system clock and a plain strobe-style register port.
package hsc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Structure.
  localparam int N_CH = 2;              // Two independent counter channels.
  localparam int ADDR_W = 8;            // Register port address width.
  localparam int CNT_W = 32;            // Running and window counter width.
  localparam int PUB_W = 16;            // Published value width.
  localparam int NUM_W = 48;            // Divider numerator width.
  localparam int DEN_W = 16;            // Divider denominator width.

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 10;    // System clock period in ns.
  localparam int MS_TIME_NS = 1000000;  // One millisecond in ns.
  localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Clocks per ms.
  localparam logic [NUM_W-1:0] MS_PER_S = 48'h0000_0000_03E8; // Milliseconds per second.

  ////////////////////////////////////////////////////////////////////////////////
  // Register map: byte offsets inside one channel, channel select in address bit 6.
  localparam int CH_SEL_BIT = 6;        // Address bit that picks the channel.
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_WINDOW = 6'h04;
  localparam logic [5:0] OFS_DIVISOR = 6'h08;
  localparam logic [5:0] OFS_COUNT = 6'h0C;
  localparam logic [5:0] OFS_FREQ = 6'h10;
  localparam logic [5:0] OFS_PUBLIC = 6'h14;
  localparam logic [5:0] OFS_FILT = 6'h18;
  localparam logic [5:0] OFS_MIN = 6'h1C;
  localparam logic [5:0] OFS_MAX = 6'h20;

  // Control register fields.
  localparam int CTRL_EN_BIT = 0;       // Channel enable.
  localparam int CTRL_FREQ_BIT = 1;     // 1: publish frequency, 0: publish cycle count.
  localparam int CTRL_ROR_BIT = 2;      // Clear the running count when it is read.
  localparam int CTRL_SHIFT_LSB = 4;    // Filter shift, four bits.
  localparam int CTRL_LIMIT_LSB = 16;   // Outlier limit, sixteen bits, zero disables.

  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] WINDOW_RST = 16'h03E8;
  localparam logic [15:0] DIVISOR_RST = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier for one register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hsc_bus_req_t;

  // Result sequencer of one channel, Gray coded along idle, frequency, publish.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FREQ = 2'b01,
    SEQ_PUB = 2'b11
  } hsc_seq_t;

endpackage : hsc_pkg

/* logic/hsc_readme_placeholder_never.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* logic/hsc_top.sv */
// Two-channel high speed pulse counter with frequency measurement and scaled output.
// Assumes sig_in is synchronous-safe after the local two-stage synchroniser and that
// software uses the one-cycle strobe register port with read data one cycle later.
//
// How it works
// (RULE1) Count input cycles; offer count and frequency.
// (RULE2) Frequency is window cycles over window time.
// (RULE3) Window in ms; frequency refreshed per window.
// (RULE4) Software should pick windows dividing 1000 ms.
// (RULE5) Count readable; optional clear on read.
// (RULE6) Control selects count or frequency published.
// (RULE7) Divide selected value before 16-bit publish.
// (RULE8) Filter, min/max, outliers only in frequency mode.
// (RULE9) Filter chain steps once per finished window.
// (RULE10) Two independent channels, each own input.
// (RULE11) Synchronise input, count each rising edge.
`timescale 1ns/1ps
`default_nettype none
module hsc_top #(
  parameter int MS_CYCLES = hsc_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [hsc_pkg::N_CH-1:0] sig_in,
  input wire hsc_pkg::hsc_bus_req_t bus_req,
  output logic [31:0] rdata,
  output logic [hsc_pkg::N_CH-1:0][hsc_pkg::PUB_W-1:0] pub_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Shared millisecond tick, so both channels see the same time base.
  logic [31:0] ms_cnt_q, ms_cnt_d;      // Clocks within the current millisecond.
  logic ms_tick;                        // High on the last clock of a millisecond.

  // Count up and wrap; the tick marks each whole millisecond.
  always_comb begin
    ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
    ms_cnt_d = ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
  end

  // Register the millisecond counter.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_cnt_q <= ms_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode shared by all channels.
  logic [5:0] ofs;                      // Offset within a channel.
  logic in_map;                         // Address lies inside the channel area.
  logic [hsc_pkg::N_CH-1:0][31:0] ch_rdata; // Read word offered by each channel.
  logic [hsc_pkg::N_CH-1:0] ch_hit;     // Channel is picked by the read address.

  assign ofs = bus_req.addr[5:0];
  assign in_map = (bus_req.addr[hsc_pkg::ADDR_W-1] == 1'b0);

  ////////////////////////////////////////////////////////////////////////////////
  // One block of logic per channel; the channels share only the millisecond tick and the address decode.
  for (genvar g = 0; g < hsc_pkg::N_CH; g++) begin : g_ch  // see (RULE10)
    logic sel;                          // Bus request addresses this channel.
    logic wr_ctrl, wr_win, wr_div, wr_mm, rd_cnt;
    logic [31:0] ctrl_q, ctrl_d;        // Enable, mode, clear-on-read, filter settings.
    logic [15:0] win_q, win_d;          // Window length in milliseconds.
    logic [15:0] divsr_q, divsr_d;      // Divisor before publishing.
    logic [2:0] sync_q, sync_d;         // Synchroniser stages and edge history.
    logic edge_det;                     // One rising edge of the input seen.
    logic [31:0] cnt_q, cnt_d;          // Running cycle count.
    logic [31:0] wcnt_q, wcnt_d;        // Cycles inside the current window.
    logic [15:0] wms_q, wms_d;          // Milliseconds elapsed in the window.
    logic win_end;                      // Current window finishes now.
    logic [15:0] win_len;               // Window length, zero read as one.
    hsc_pkg::hsc_seq_t seq_q, seq_d;    // Result sequencer.
    logic [31:0] freq_q, freq_d;        // Last frequency in Hz.
    logic [15:0] pub_q, pub_d;          // Published value.
    logic [31:0] filt_q, filt_d;        // Filtered frequency.
    logic [31:0] min_q, min_d, max_q, max_d;
    logic init_q, init_d;               // Chain has taken its first sample.
    logic div_start, div_done, div_busy;
    logic [hsc_pkg::NUM_W-1:0] div_num, div_quo;
    logic [15:0] div_den;
    logic [32:0] diff;                  // Signed sample minus filter.
    logic [32:0] step;                  // Filter step after the shift.
    logic [32:0] mag;                   // Magnitude of the difference.
    logic [31:0] fsamp;                 // Frequency result saturated to 32 bits.

    assign sel = in_map && (bus_req.addr[hsc_pkg::CH_SEL_BIT] == 1'(g));
    assign wr_ctrl = sel && bus_req.wr && ofs == hsc_pkg::OFS_CTRL;
    assign wr_win = sel && bus_req.wr && ofs == hsc_pkg::OFS_WINDOW;
    assign wr_div = sel && bus_req.wr && ofs == hsc_pkg::OFS_DIVISOR;
    assign wr_mm = sel && bus_req.wr && ofs == hsc_pkg::OFS_MAX;
    assign rd_cnt = sel && bus_req.rd && ofs == hsc_pkg::OFS_COUNT;

    // Configuration registers written by software.
    always_comb begin
      ctrl_d = wr_ctrl ? bus_req.wdata : ctrl_q;
      win_d = wr_win ? bus_req.wdata[15:0] : win_q;  // see (RULE3)
      divsr_d = wr_div ? bus_req.wdata[15:0] : divsr_q;  // see (RULE7)
    end

    // Input counting: only the synchronised stages feed the edge detector.
    always_comb begin
      sync_d = {sync_q[1:0], sig_in[g]};
      edge_det = sync_q[1] && !sync_q[2];  // see (RULE11)
      win_len = (win_q == 16'h0000) ? 16'h0001 : win_q;
      win_end = ctrl_q[hsc_pkg::CTRL_EN_BIT] && ms_tick && (wms_q + 16'h0001 >= win_len);
      cnt_d = cnt_q;
      // A clearing read and an edge in the same cycle leave a count of one.
      if (rd_cnt && ctrl_q[hsc_pkg::CTRL_ROR_BIT]) begin
        cnt_d = 32'h0000_0000;  // see (RULE5)
      end
      if (edge_det && ctrl_q[hsc_pkg::CTRL_EN_BIT]) begin
        cnt_d = cnt_d + 32'h0000_0001;  // see (RULE1)
      end
      wms_d = !ctrl_q[hsc_pkg::CTRL_EN_BIT] ? 16'h0000 : win_end ? 16'h0000 : ms_tick ? wms_q + 16'h0001 : wms_q;
      if (!ctrl_q[hsc_pkg::CTRL_EN_BIT] || win_end) begin
        wcnt_d = 32'h0000_0000;
      end else begin
        wcnt_d = wcnt_q + 32'(edge_det);
      end
    end

    // Result sequencer: frequency division and processed chain in frequency mode, then the publish division.
    always_comb begin
      seq_d = seq_q;
      freq_d = freq_q;
      pub_d = pub_q;
      filt_d = filt_q;
      min_d = min_q;
      max_d = max_q;
      init_d = init_q;
      div_start = 1'b0;
      div_num = '0;
      div_den = win_len;
      fsamp = (div_quo[47:32] != 16'h0000) ? 32'hFFFF_FFFF : div_quo[31:0];
      diff = {1'b0, fsamp} - {1'b0, filt_q};
      step = $signed(diff) >>> ctrl_q[hsc_pkg::CTRL_SHIFT_LSB +: 4];
      mag = diff[32] ? 33'(-diff) : diff;
      if (wr_mm) begin
        init_d = 1'b0;
      end
      case (seq_q)
        hsc_pkg::SEQ_IDLE: begin
          // A busy divider would drop the start, so the window is skipped instead.
          if (!div_busy && win_end && ctrl_q[hsc_pkg::CTRL_FREQ_BIT]) begin
            // Cycles times 1000 over window ms gives Hz.
            div_num = hsc_pkg::NUM_W'(wcnt_q + 32'(edge_det)) * hsc_pkg::MS_PER_S;  // see (RULE2)
            div_den = win_len;
            div_start = 1'b1;
            seq_d = hsc_pkg::SEQ_FREQ;
          end else if (!div_busy && win_end) begin
            div_num = hsc_pkg::NUM_W'(cnt_q);  // see (RULE6)
            div_den = divsr_q;
            div_start = 1'b1;
            seq_d = hsc_pkg::SEQ_PUB;
          end
        end
        hsc_pkg::SEQ_FREQ: begin
          if (div_done) begin
            freq_d = fsamp;  // see (RULE3)
            // The chain steps here only, once per finished window.
            if (!init_q || wr_mm) begin  // see (RULE8) (RULE9)
              filt_d = fsamp;
              min_d = fsamp;
              max_d = fsamp;
              init_d = 1'b1;
            end else if (ctrl_q[31:16] == 16'h0000 || mag <= 33'(ctrl_q[31:16])) begin
              // Samples far from the filtered value are dropped as outliers.
              filt_d = filt_q + step[31:0];
              min_d = (fsamp < min_q) ? fsamp : min_q;
              max_d = (fsamp > max_q) ? fsamp : max_q;
            end
            div_num = hsc_pkg::NUM_W'(fsamp);  // see (RULE6)
            div_den = divsr_q;
            div_start = 1'b1;
            seq_d = hsc_pkg::SEQ_PUB;
          end
        end
        hsc_pkg::SEQ_PUB: begin
          if (div_done) begin
            // Saturate only if the divisor was too small to keep it in range.
            pub_d = (div_quo[47:16] != 32'h0000_0000) ? 16'hFFFF : div_quo[15:0];  // see (RULE7)
            seq_d = hsc_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seq_d = hsc_pkg::SEQ_IDLE;
        end
      endcase
    end

    hsc_div #(
      .NW(hsc_pkg::NUM_W),
      .DW(hsc_pkg::DEN_W)
    ) u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .quo(div_quo),
      .done(div_done),
      .busy(div_busy)
    );

    // Register stage of the channel.
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        ctrl_q <= hsc_pkg::CTRL_RST;
        win_q <= hsc_pkg::WINDOW_RST;
        divsr_q <= hsc_pkg::DIVISOR_RST;
        sync_q <= 3'h0;
        cnt_q <= 32'h0000_0000;
        wcnt_q <= 32'h0000_0000;
        wms_q <= 16'h0000;
        seq_q <= hsc_pkg::SEQ_IDLE;
        freq_q <= 32'h0000_0000;
        pub_q <= 16'h0000;
        filt_q <= 32'h0000_0000;
        min_q <= 32'h0000_0000;
        max_q <= 32'h0000_0000;
        init_q <= 1'b0;
      end else begin
        ctrl_q <= ctrl_d;
        win_q <= win_d;
        divsr_q <= divsr_d;
        sync_q <= sync_d;
        cnt_q <= cnt_d;
        wcnt_q <= wcnt_d;
        wms_q <= wms_d;
        seq_q <= seq_d;
        freq_q <= freq_d;
        pub_q <= pub_d;
        filt_q <= filt_d;
        min_q <= min_d;
        max_q <= max_d;
        init_q <= init_d;
      end
    end

    // Read word of this channel; unmapped offsets answer zero.
    always_comb begin
      ch_hit[g] = sel;
      case (ofs)
        hsc_pkg::OFS_CTRL: ch_rdata[g] = ctrl_q;
        hsc_pkg::OFS_WINDOW: ch_rdata[g] = {16'h0000, win_q};
        hsc_pkg::OFS_DIVISOR: ch_rdata[g] = {16'h0000, divsr_q};
        hsc_pkg::OFS_COUNT: ch_rdata[g] = cnt_q;  // see (RULE5)
        hsc_pkg::OFS_FREQ: ch_rdata[g] = freq_q;
        hsc_pkg::OFS_PUBLIC: ch_rdata[g] = {16'h0000, pub_q};
        hsc_pkg::OFS_FILT: ch_rdata[g] = filt_q;
        hsc_pkg::OFS_MIN: ch_rdata[g] = min_q;
        hsc_pkg::OFS_MAX: ch_rdata[g] = max_q;
        default: ch_rdata[g] = 32'h0000_0000;
      endcase
    end

    assign pub_data[g] = pub_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data register: valid only in the cycle after the read strobe.
  logic [31:0] rdata_q, rdata_d;

  // Pick the addressed channel; anything else reads zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < hsc_pkg::N_CH; i++) begin
      if (bus_req.rd && ch_hit[i]) begin
        rdata_d = ch_rdata[i];
      end
    end
  end

  // Register the read answer.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule : hsc_top
`default_nettype wire

/* sim/hsc_properties.sv */
// Checker of the counter's register port and published values.
// Assumes it sees only the top ports; it keeps its own copy of the writable registers.
`timescale 1ns/1ps
`default_nettype none
module hsc_checker #(
  parameter int MS_CYCLES = hsc_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire hsc_pkg::hsc_bus_req_t bus_req,
  input wire logic [31:0] rdata,
  input wire logic [hsc_pkg::N_CH-1:0][hsc_pkg::PUB_W-1:0] pub_data
);
  logic [1:0][31:0] ctrl_q, ctrl_d; // Shadow of each control register.
  logic [1:0][15:0] win_q, win_d, div_q, div_d; // Shadow window and divisor.
  logic [1:0] en_q, en_d, fq_q, fq_d; // Channel was ever enabled, ever in frequency mode.
  logic ch; // Channel picked by the address.
  logic [5:0] ofs; // Offset inside the channel.
  logic rdm; // A read of a mapped channel.
  assign ch = bus_req.addr[hsc_pkg::CH_SEL_BIT];
  assign ofs = bus_req.addr[5:0];
  assign rdm = bus_req.rd && !bus_req.addr[7];
  // Next shadow values; the sticky flags follow the value being written so they never lag.
  always_comb begin
    ctrl_d = ctrl_q;
    win_d = win_q;
    div_d = div_q;
    if (bus_req.wr && !bus_req.addr[7]) begin
      if (ofs == hsc_pkg::OFS_CTRL) ctrl_d[ch] = bus_req.wdata;
      if (ofs == hsc_pkg::OFS_WINDOW) win_d[ch] = bus_req.wdata[15:0];
      if (ofs == hsc_pkg::OFS_DIVISOR) div_d[ch] = bus_req.wdata[15:0];
    end
    en_d = en_q | {ctrl_d[1][0], ctrl_d[0][0]};
    fq_d = fq_q | {ctrl_d[1][1], ctrl_d[0][1]};
  end
  // Registers the shadows, loaded with the register reset values by the synchronous reset.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= {2{hsc_pkg::CTRL_RST}};
      win_q <= {2{hsc_pkg::WINDOW_RST}};
      div_q <= {2{hsc_pkg::DIVISOR_RST}};
      en_q <= 2'h0;
      fq_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      win_q <= win_d;
      div_q <= div_d;
      en_q <= en_d;
      fq_q <= fq_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RDATA_IDLE: assert property (!bus_req.rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED: assert property (bus_req.rd && (bus_req.addr[7] || ofs > hsc_pkg::OFS_MAX) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_RB: assert property (rdm && ofs == hsc_pkg::OFS_CTRL |=>
    rdata == ctrl_q[$past(ch)])
    else $error("control readback wrong");
  AST_WINDOW_RB: assert property (rdm && ofs == hsc_pkg::OFS_WINDOW |=> rdata == {16'h0, win_q[$past(ch)]})
    else $error("window readback wrong");
  AST_DIVISOR_RB: assert property (rdm && ofs == hsc_pkg::OFS_DIVISOR |=> rdata == {16'h0, div_q[$past(ch)]})
    else $error("divisor readback wrong");
  AST_COUNT_OFF: assert property (rdm && ofs == hsc_pkg::OFS_COUNT && !en_q[ch] |=> rdata == 32'h0)
    else $error("count moved on a channel never enabled");
  AST_FILT_IDLE: assert property (rdm && ofs >= hsc_pkg::OFS_FILT && ofs <= hsc_pkg::OFS_MAX && !fq_q[ch]
    |=> rdata == 32'h0)
    else $error("filter chain moved outside frequency mode");
  AST_PUB_RESET: assert property (disable iff (1'b0) !rst_n |=> pub_data == '0)
    else $error("published value not cleared by reset");
  AST_PUB_QUIET: assert property ((en_q[0] || pub_data[0] == 16'h0) && (en_q[1] || pub_data[1] == 16'h0))
    else $error("published value moved on a channel never enabled");
endmodule : hsc_checker
bind hsc_top hsc_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
  .rdata(rdata), .pub_data(pub_data));
`default_nettype wire

/* sim/hsc_src.sv */
// Model of the fast external signal that feeds one counter channel.
// Assumes the bench loads a pulse count or turns on the free-running square wave.
`timescale 1ns/1ps
`default_nettype none
module hsc_src (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic load,
  input wire logic [7:0] n,
  output logic sig
);
  logic [7:0] left = 8'h00; // Pulses still to send, loaded from n by load.
  logic [1:0] ph = 2'h0; // Phase inside one four-clock period.
  initial sig = 1'b0;
  // Each pulse is high while the phase top bit is set, so high and low last at least one clock.
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    if (load) begin
      left <= n;
      sig <= 1'b0;
    end else if (run || left != 8'h00) begin
      sig <= ph[1];
      if (!run && ph == 2'h3) begin
        left <= left - 8'h01;
      end
    end else begin
      sig <= 1'b0; // The line idles low between bursts.
    end
  end
endmodule : hsc_src
`default_nettype wire

/* sim/test_high_speed_pulse_counter.sv */
// Self-checking bench of the two-channel pulse counter.
// Assumes a short millisecond parameter so that windows last a few tens of clocks.
`timescale 1ns/1ps
`default_nettype none
module test_high_speed_pulse_counter;
  localparam int MSC = 20; // Clocks per millisecond in this run.
  localparam int LIMIT = 20000; // Cycle ceiling; the tests need about 1200.
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  hsc_pkg::hsc_bus_req_t bus_req = '0;
  wire logic [1:0] sig_in;
  logic [31:0] rdata;
  logic [1:0][15:0] pub_data;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [1:0] src_run = 2'b00; // Free-running square wave per source.
  logic [1:0] src_load = 2'b00; // One-clock load of a burst length.
  logic [1:0][7:0] src_n = '0; // Burst length per source.
  always #5 ref_clk = ~ref_clk;
  hsc_top #(.MS_CYCLES(MSC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sig_in(sig_in), .bus_req(bus_req),
    .rdata(rdata), .pub_data(pub_data));
  hsc_src i_src0 (.ref_clk(ref_clk), .run(src_run[0]), .load(src_load[0]), .n(src_n[0]), .sig(sig_in[0]));
  hsc_src i_src1 (.ref_clk(ref_clk), .run(src_run[1]), .load(src_load[1]), .n(src_n[1]), .sig(sig_in[1]));
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // Cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("Error timeout expected %0d seen %0d", LIMIT - 1, cyc);
      end_of_test();
    end
  end
  function automatic logic [7:0] ad(input int c, input logic [5:0] o);
    return {1'b0, c[0], o};
  endfunction : ad
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One write cycle, then one idle edge so the strobe is never lowered and raised at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
    @(posedge ref_clk);
    check(name, d, exp);
  endtask : rdchk
  // Sends bursts on both inputs; four clocks a pulse plus room for the synchroniser.
  task automatic pulses(input int n0, input int n1);
    src_n <= {8'(n1), 8'(n0)};
    src_load <= 2'b11;
    @(posedge ref_clk);
    src_load <= 2'b00;
    repeat (4 * ((n0 > n1) ? n0 : n1) + 12) @(posedge ref_clk);
  endtask : pulses
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int c = 0; c < 2; c++) begin
      rdchk(ad(c, hsc_pkg::OFS_CTRL), 32'h0000_0000, "ctrl");
      rdchk(ad(c, hsc_pkg::OFS_WINDOW), 32'h0000_03E8, "window");
      rdchk(ad(c, hsc_pkg::OFS_DIVISOR), 32'h0000_0001, "divisor");
    end
    wr(8'h80, 32'hFFFF_FFFF);
    rdchk(8'h80, 32'h0000_0000, "unmapped");
    check("pub", pub_data, 32'h0000_0000);
    $display("Test reset done");
  endtask : t_reset
  // A disabled channel ignores its input while the other counts.
  task automatic t_count();
    wr(ad(0, hsc_pkg::OFS_CTRL), 32'h0000_0001);
    pulses(7, 5);
    rdchk(ad(0, hsc_pkg::OFS_COUNT), 32'h0000_0007, "count0");
    rdchk(ad(1, hsc_pkg::OFS_COUNT), 32'h0000_0000, "count1 off");
    wr(ad(1, hsc_pkg::OFS_CTRL), 32'h0000_0001);
    pulses(0, 3);
    rdchk(ad(1, hsc_pkg::OFS_COUNT), 32'h0000_0003, "count1");
    rdchk(ad(0, hsc_pkg::OFS_COUNT), 32'h0000_0007, "count0 kept");
    $display("Test count done");
  endtask : t_count
  task automatic t_ror();
    wr(ad(0, hsc_pkg::OFS_CTRL), 32'h0000_0005);
    rdchk(ad(0, hsc_pkg::OFS_COUNT), 32'h0000_0007, "ror first");
    rdchk(ad(0, hsc_pkg::OFS_COUNT), 32'h0000_0000, "ror cleared");
    wr(ad(0, hsc_pkg::OFS_CTRL), 32'h0000_0001);
    pulses(4, 0);
    rdchk(ad(0, hsc_pkg::OFS_COUNT), 32'h0000_0004, "plain first");
    rdchk(ad(0, hsc_pkg::OFS_COUNT), 32'h0000_0004, "plain kept");
    $display("Test clear on read done");
  endtask : t_ror
  // Count mode publishes count over divisor at the end of a one-millisecond window.
  task automatic t_pub_count();
    wr(ad(0, hsc_pkg::OFS_DIVISOR), 32'h0000_0002);
    wr(ad(0, hsc_pkg::OFS_WINDOW), 32'h0000_0001);
    wr(ad(1, hsc_pkg::OFS_WINDOW), 32'h0000_0001);
    repeat (3 * MSC + 120) @(posedge ref_clk);
    check("pub1 count", {16'h0, pub_data[1]}, 32'h0000_0003);
    rdchk(ad(0, hsc_pkg::OFS_PUBLIC), 32'h0000_0002, "public count");
    check("pub0 count", {16'h0, pub_data[0]}, 32'h0000_0002);
    rdchk(ad(0, hsc_pkg::OFS_FILT), 32'h0000_0000, "filt count mode");
    $display("Test count publish done");
  endtask : t_pub_count
  // A four-clock square wave gives ten edges in a two-millisecond window: 5000 Hz.
  task automatic t_freq();
    wr(ad(0, hsc_pkg::OFS_DIVISOR), 32'h0000_0064);
    wr(ad(0, hsc_pkg::OFS_WINDOW), 32'h0000_0002);
    src_run <= 2'b01;
    // Outlier limit of one and a filter shift of one, so a stopped input is excluded.
    wr(ad(0, hsc_pkg::OFS_CTRL), 32'h0001_0013);
    repeat (300) @(posedge ref_clk);
    wr(ad(0, hsc_pkg::OFS_MAX), 32'h0000_0000);
    repeat (4 * MSC + 160) @(posedge ref_clk);
    rdchk(ad(0, hsc_pkg::OFS_FREQ), 32'h0000_1388, "freq");
    rdchk(ad(0, hsc_pkg::OFS_PUBLIC), 32'h0000_0032, "public freq");
    check("pub0 freq", {16'h0, pub_data[0]}, 32'h0000_0032);
    rdchk(ad(0, hsc_pkg::OFS_FILT), 32'h0000_1388, "filt");
    rdchk(ad(0, hsc_pkg::OFS_MIN), 32'h0000_1388, "min");
    rdchk(ad(0, hsc_pkg::OFS_MAX), 32'h0000_1388, "max");
    rdchk(ad(1, hsc_pkg::OFS_FILT), 32'h0000_0000, "filt1 count mode");
    src_run <= 2'b00;
    repeat (300) @(posedge ref_clk);
    rdchk(ad(0, hsc_pkg::OFS_FREQ), 32'h0000_0000, "freq stopped");
    rdchk(ad(0, hsc_pkg::OFS_FILT), 32'h0000_1388, "filt outlier");
    rdchk(ad(0, hsc_pkg::OFS_MIN), 32'h0000_1388, "min outlier");
    $display("Test frequency done");
  endtask : t_freq
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_count();
    t_ror();
    t_pub_count();
    t_freq();
    end_of_test();
  end
endmodule : test_high_speed_pulse_counter
`default_nettype wire
